/* File: bench/sdbis_ctrl_model.sv */
// partner model: external memory controller driving the command pins
// assumes one bench process calls its tasks, one command per rising edge
`timescale 1ns/1ps
module sdbis_ctrl_model (
  input wire logic clock_i,
  output logic cke_o,
  output sdbis_pkg::sdbis_pins_t pins_o,
  output logic [sdbis_pkg::DATA_W-1:0] wr_data_o
);
  // ==========================================================
  // idle drive
  initial
  begin
    cke_o = 1'b1;
    pins_o = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'ha5};
    wr_data_o = 16'h5a5a;
  end

  // ==========================================================
  // command issue
  // only sequences the bench asks for: no mode load, one refresh into a write burst;
  // inside a burst no stop, read or store into an auto-close read
  task automatic send(input logic [2:0] code, input logic bank, input logic a10,
                      input logic [7:0] col, input logic [15:0] data);
    @(posedge clock_i);
    cke_o <= 1'b1;
    pins_o <= '{1'b0, code[2], code[1], code[0], bank, a10, col};
    wr_data_o <= data;
  endtask : send

  // clock enable low for one edge: the device holds its burst state, but precharge timers and the fifo keep running
  task automatic freeze();
    @(posedge clock_i);
    cke_o <= 1'b0;
  endtask : freeze

  // deselected cycle: strobes and address flip so nothing stale looks held
  task automatic desel(input logic [15:0] data);
    @(posedge clock_i);
    cke_o <= 1'b1;
    pins_o <= '{1'b1, ~pins_o.ras_n, ~pins_o.cas_n, ~pins_o.we_n, ~pins_o.bank,
                ~pins_o.a10, ~pins_o.col};
    wr_data_o <= data;
  endtask : desel
endmodule : sdbis_ctrl_model

/* File: bench/tb.sv */
// self-checking bench for the burst engine with a controller model
// assumes commands are taken at each rising edge, burst length 4
`timescale 1ns/1ps
module tb;
  localparam logic [2:0] C_NOP = 3'h7;
  localparam logic [2:0] C_STOP = 3'h6;
  localparam logic [2:0] C_READ = 3'h5;
  localparam logic [2:0] C_STORE = 3'h4;
  localparam logic [2:0] C_OPEN = 3'h3;
  localparam logic [2:0] C_CLOSE = 3'h2;
  localparam logic [2:0] C_REFRESH = 3'h1;
  logic illegal;
  logic clock;
  logic rst_n;
  logic cke;
  logic rd_ready;
  logic rd_valid;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [1:0] bank_active;
  logic [1:0] precharging;
  sdbis_pkg::sdbis_pins_t pins;
  sdbis_pkg::sdbis_burst_t burst_state;
  int n_fail;
  int samples_checked;
  logic [15:0] q[$];

  sdbis_ctrl_model sdbis_ctrl_model_i (.clock_i(clock), .cke_o(cke), .pins_o(pins),
    .wr_data_o(wr_data));
  sdbis_burst_ctrl sdbis_burst_ctrl_i (.clock_i(clock), .rst_n_i(rst_n), .cke_i(cke),
    .pins_i(pins), .wr_data_i(wr_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .rd_ready_i(rd_ready), .bank_active_o(bank_active), .precharging_o(precharging),
    .burst_state_o(burst_state), .illegal_o(illegal));

  // ==========================================================
  // clock and read-side collector
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      q.push_back(rd_data);
  end

  // ==========================================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // returns 1 ns after the edge so registered outputs have landed
  task automatic cmd(input logic [2:0] c, input logic b, input logic a10,
                     input logic [7:0] col, input logic [15:0] d);
    sdbis_ctrl_model_i.send(c, b, a10, col, d);
    #1;
  endtask : cmd

  task automatic nops(input int n);
    repeat (n) cmd(C_NOP, 1'b0, 1'b0, 8'h00, 16'h0000);
  endtask : nops

  task automatic st(input sdbis_pkg::sdbis_burst_t s);
    check(16'(burst_state), 16'(s));
  endtask : st

  task automatic burst_wr(input logic a10, input logic [7:0] col, input logic [15:0] base);
    cmd(C_STORE, 1'b0, a10, col, base);
    for (int i = 1; i < 4; i++)
      cmd(C_NOP, 1'b0, 1'b0, 8'h00, base + 16'(i));
  endtask : burst_wr

  task automatic tail_chk(input logic [15:0] base);
    check(16'(q.size() >= 4), 16'h0001);
    if (q.size() >= 4)
      for (int i = 0; i < 4; i++)
        check(q[q.size() - 4 + i], base + 16'(i));
    q.delete();
  endtask : tail_chk

  // bounded wait for a bank to start precharging, noting a state on the way
  task automatic await_pre(input int b, input sdbis_pkg::sdbis_burst_t s);
    bit seen_s;
    int k;
    seen_s = 1'b0;
    for (k = 0; k < 12 && precharging[b] !== 1'b1; k++)
    begin
      if (burst_state === s)
        seen_s = 1'b1;
      nops(1);
    end
    if (k == 12)
    begin
      n_fail++;
      $display("BAD t=%0t precharge never started", $time);
      report_and_stop();
    end
    check(16'(seen_s), 16'h0001);
  endtask : await_pre

  // ==========================================================
  // scenarios
  task automatic s_write_idle();
    cmd(C_STORE, 1'b0, 1'b0, 8'h10, 16'ha000);
    cmd(C_NOP, 1'b0, 1'b0, 8'h00, 16'ha001);
    st(sdbis_pkg::B_WRITE);
    sdbis_ctrl_model_i.desel(16'ha002);
    #1;
    sdbis_ctrl_model_i.freeze();
    #1;
    cmd(C_NOP, 1'b0, 1'b0, 8'h00, 16'ha003);
    st(sdbis_pkg::B_WRITE);
    nops(1);
    st(sdbis_pkg::B_WREC);
    nops(1);
    st(sdbis_pkg::B_NONE);
    check(16'(bank_active), 16'h0001);
  endtask : s_write_idle

  task automatic s_write_restart();
    cmd(C_STORE, 1'b0, 1'b0, 8'h30, 16'hc000);
    burst_wr(1'b0, 8'h20, 16'hb000);
    st(sdbis_pkg::B_WRITE);
    nops(3);
    cmd(C_READ, 1'b0, 1'b0, 8'h20, 16'h0000);
    nops(6);
    st(sdbis_pkg::B_NONE);
    check(16'(bank_active), 16'h0001);
    tail_chk(16'hb000);
  endtask : s_write_restart

  task automatic s_write_then_read();
    cmd(C_STORE, 1'b0, 1'b0, 8'h40, 16'hd000);
    cmd(C_READ, 1'b0, 1'b0, 8'h10, 16'hd001);
    nops(1);
    st(sdbis_pkg::B_READ);
    nops(5);
    tail_chk(16'ha000);
    cmd(C_STORE, 1'b0, 1'b0, 8'h50, 16'he000);
    cmd(C_REFRESH, 1'b0, 1'b0, 8'h00, 16'h0000);
    nops(1);
    check(16'(illegal), 16'h0001);
    st(sdbis_pkg::B_WRITE);
    cmd(C_STOP, 1'b0, 1'b0, 8'h00, 16'h0000);
    nops(1);
    st(sdbis_pkg::B_NONE);
    check(16'(illegal), 16'h0000);
    check(16'(bank_active), 16'h0001);
  endtask : s_write_then_read

  task automatic s_read_breaks();
    cmd(C_READ, 1'b0, 1'b0, 8'h10, 16'h0000);
    nops(1);
    cmd(C_STOP, 1'b0, 1'b0, 8'h00, 16'h0000);
    nops(1);
    st(sdbis_pkg::B_NONE);
    check(16'(bank_active), 16'h0001);
    nops(4);
    check(16'(q.size() < 4), 16'h0001);
    q.delete();
    cmd(C_READ, 1'b0, 1'b0, 8'h10, 16'h0000);
    nops(1);
    cmd(C_READ, 1'b0, 1'b0, 8'h20, 16'h0000);
    nops(6);
    tail_chk(16'hb000);
    cmd(C_READ, 1'b0, 1'b0, 8'h10, 16'h0000);
    nops(1);
    burst_wr(1'b0, 8'h60, 16'hf000);
    st(sdbis_pkg::B_WRITE);
    nops(3);
    q.delete();
    cmd(C_READ, 1'b0, 1'b0, 8'h60, 16'h0000);
    nops(6);
    tail_chk(16'hf000);
    cmd(C_READ, 1'b0, 1'b0, 8'h10, 16'h0000);
    nops(1);
    cmd(C_CLOSE, 1'b0, 1'b0, 8'h00, 16'h0000);
    nops(1);
    check(16'(bank_active), 16'h0000);
    check(16'(precharging), 16'h0001);
    nops(4);
    q.delete();
  endtask : s_read_breaks

  task automatic s_closing();
    cmd(C_OPEN, 1'b0, 1'b0, 8'h00, 16'h0000);
    cmd(C_OPEN, 1'b1, 1'b0, 8'h00, 16'h0000);
    cmd(C_STORE, 1'b0, 1'b0, 8'h10, 16'ha000);
    cmd(C_CLOSE, 1'b0, 1'b1, 8'h00, 16'h0000);
    nops(1);
    check(16'(bank_active), 16'h0000);
    check(16'(precharging), 16'h0003);
    nops(3);
    cmd(C_OPEN, 1'b0, 1'b0, 8'h00, 16'h0000);
    cmd(C_READ, 1'b0, 1'b1, 8'h20, 16'h0000);
    await_pre(0, sdbis_pkg::B_READ_AC);
    check(16'(bank_active), 16'h0000);
    nops(3);
    tail_chk(16'hb000);
    cmd(C_OPEN, 1'b0, 1'b0, 8'h00, 16'h0000);
    burst_wr(1'b1, 8'h70, 16'h7000);
    st(sdbis_pkg::B_WRITE_AC);
    await_pre(0, sdbis_pkg::B_WREC_AC);
    check(16'(bank_active), 16'h0000);
    nops(3);
  endtask : s_closing

  // consumer stalls: fifo fills, third burst waits, nothing is lost
  task automatic s_fifo_full();
    cmd(C_OPEN, 1'b0, 1'b0, 8'h00, 16'h0000);
    @(posedge clock);
    rd_ready <= 1'b0;
    #1;
    cmd(C_READ, 1'b0, 1'b0, 8'h10, 16'h0000);
    nops(4);
    cmd(C_READ, 1'b0, 1'b0, 8'h20, 16'h0000);
    nops(4);
    cmd(C_READ, 1'b0, 1'b0, 8'h10, 16'h0000);
    nops(6);
    st(sdbis_pkg::B_READ);
    check(16'(rd_valid), 16'h0001);
    @(posedge clock);
    rd_ready <= 1'b1;
    #1;
    nops(12);
    check(16'(q.size()), 16'd12);
    if (q.size() > 4)
      check(q[4], 16'hb000);
    tail_chk(16'ha000);
  endtask : s_fifo_full

  // ==========================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    rd_ready = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    st(sdbis_pkg::B_NONE);
    check(16'(bank_active), 16'h0000);
    check(16'(rd_valid), 16'h0000);
    cmd(C_OPEN, 1'b0, 1'b0, 8'h00, 16'h0000);
    s_write_idle();
    s_write_restart();
    s_write_then_read();
    s_read_breaks();
    s_closing();
    s_fifo_full();
    report_and_stop();
  end
endmodule : tb

/* File: design/sdbis_burst_ctrl.sv */
// burst engine of a two-bank sdram: reacts to commands during bursts
// assumes commands sampled each rising edge; one burst active at a time
`timescale 1ns/1ps
module sdbis_burst_ctrl (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cke_i,
  input wire sdbis_pkg::sdbis_pins_t pins_i,
  input wire logic [sdbis_pkg::DATA_W-1:0] wr_data_i,
  output logic [sdbis_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [1:0] bank_active_o,
  output logic [1:0] precharging_o,
  output sdbis_pkg::sdbis_burst_t burst_state_o,
  output logic illegal_o
);

  // ==========================================================
  // decode and storage
  sdbis_pkg::sdbis_cmd_info_t info;
  sdbis_pkg::sdbis_burst_t state;
  sdbis_pkg::sdbis_burst_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [sdbis_pkg::COL_W-1:0] col;
  logic [sdbis_pkg::COL_W-1:0] next_col;
  logic bank;
  logic next_bank;
  logic [1:0] rec_cnt;
  logic [1:0] next_rec_cnt;
  logic [1:0] bank_open;
  logic [1:0] pre_cnt [2];
  logic [1:0] pre_req;
  logic [1:0] close_mask;
  logic next_illegal;
  logic wr_en;
  logic [sdbis_pkg::COL_W:0] wr_addr;
  logic [sdbis_pkg::COL_W:0] rd_addr;
  logic [sdbis_pkg::DATA_W-1:0] mem [2**(sdbis_pkg::COL_W+1)];
  logic fifo_in_ready;
  logic rd_step;
  logic go_read;
  logic go_store;
  logic allow_start;

  sdbis_cmd_decode u_decode (
    .cke_i(cke_i),
    .pins_i(pins_i),
    .info_o(info)
  );

  // a stalled fifo freezes the read burst, so no word is ever dropped
  sdbis_fifo #(
    .WIDTH(sdbis_pkg::DATA_W),
    .DEPTH(sdbis_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rd_step),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mem[rd_addr]),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );

  assign close_mask = info.a10 ? 2'h3 : (info.bank ? 2'h2 : 2'h1);
  assign rd_addr = {bank, col + sdbis_pkg::COL_W'(cnt)};
  assign rd_step = (state == sdbis_pkg::B_READ || state == sdbis_pkg::B_READ_AC)
    && info.kind == sdbis_pkg::CMD_NOP && fifo_in_ready;
  assign go_read = info.kind == sdbis_pkg::CMD_READ && bank_open[info.bank];
  assign go_store = info.kind == sdbis_pkg::CMD_STORE && bank_open[info.bank];
  assign allow_start = state == sdbis_pkg::B_NONE || state == sdbis_pkg::B_READ
    || state == sdbis_pkg::B_WRITE || state == sdbis_pkg::B_WREC;

  // ==========================================================
  // burst next state
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_col = col;
    next_bank = bank;
    next_rec_cnt = rec_cnt;
    pre_req = 2'h0;
    next_illegal = 1'b0;
    wr_en = 1'b0;
    wr_addr = {bank, col + sdbis_pkg::COL_W'(cnt)};
    if (allow_start && go_read)
    begin
      next_state = info.a10 ? sdbis_pkg::B_READ_AC : sdbis_pkg::B_READ;
      next_cnt = 3'h0;
      next_col = info.col;
      next_bank = info.bank;
    end
    else if (allow_start && go_store)
    begin
      next_state = info.a10 ? sdbis_pkg::B_WRITE_AC : sdbis_pkg::B_WRITE;
      next_cnt = sdbis_pkg::BURST_FIRST_NEXT;
      next_col = info.col;
      next_bank = info.bank;
      wr_en = 1'b1;
      wr_addr = {info.bank, info.col};
    end
    else
    begin
      unique case (state)
        sdbis_pkg::B_NONE:
        begin
          if (info.kind == sdbis_pkg::CMD_CLOSE)
            pre_req = close_mask;
        end
        sdbis_pkg::B_READ, sdbis_pkg::B_READ_AC:
        begin
          if (rd_step)
          begin
            if (cnt == sdbis_pkg::BURST_LAST)
            begin
              next_state = sdbis_pkg::B_NONE;
              if (state == sdbis_pkg::B_READ_AC)
                pre_req = bank ? 2'h2 : 2'h1;
            end
            else
              next_cnt = cnt + 3'h1;
          end
          else if (state == sdbis_pkg::B_READ_AC)
            next_illegal = info.kind != sdbis_pkg::CMD_NOP
              && info.kind != sdbis_pkg::CMD_HOLD;
          else if (info.kind == sdbis_pkg::CMD_BURST_STOP)
            next_state = sdbis_pkg::B_NONE;
          else if (info.kind == sdbis_pkg::CMD_CLOSE)
          begin
            next_state = sdbis_pkg::B_NONE;
            pre_req = close_mask;
          end
          else if (info.kind != sdbis_pkg::CMD_NOP && info.kind != sdbis_pkg::CMD_HOLD)
            next_illegal = 1'b1;
        end
        sdbis_pkg::B_WRITE, sdbis_pkg::B_WRITE_AC:
        begin
          if (info.kind == sdbis_pkg::CMD_NOP)
          begin
            wr_en = 1'b1;
            if (cnt == sdbis_pkg::BURST_LAST)
            begin
              next_state = (state == sdbis_pkg::B_WRITE_AC) ? sdbis_pkg::B_WREC_AC
                : sdbis_pkg::B_WREC;
              next_rec_cnt = sdbis_pkg::WR_REC_LOAD;
            end
            else
              next_cnt = cnt + 3'h1;
          end
          else if (info.kind == sdbis_pkg::CMD_HOLD)
            next_state = state;
          else if (state == sdbis_pkg::B_WRITE_AC)
            next_illegal = 1'b1;
          else if (info.kind == sdbis_pkg::CMD_BURST_STOP)
            next_state = sdbis_pkg::B_NONE;
          else if (info.kind == sdbis_pkg::CMD_CLOSE)
          begin
            next_state = sdbis_pkg::B_NONE;
            pre_req = close_mask;
          end
          else
            next_illegal = 1'b1;
        end
        sdbis_pkg::B_WREC, sdbis_pkg::B_WREC_AC:
        begin
          if (info.kind != sdbis_pkg::CMD_HOLD)
          begin
            if (rec_cnt == 2'h0)
            begin
              next_state = sdbis_pkg::B_NONE;
              if (state == sdbis_pkg::B_WREC_AC)
                pre_req = bank ? 2'h2 : 2'h1;
            end
            else
              next_rec_cnt = rec_cnt - 2'h1;
          end
        end
        default:
          next_state = sdbis_pkg::B_NONE;
      endcase
    end
  end

  // ==========================================================
  // burst registers
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state <= sdbis_pkg::B_NONE;
      cnt <= 3'h0;
      col <= '0;
      bank <= 1'b0;
      rec_cnt <= 2'h0;
      illegal_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      col <= next_col;
      bank <= next_bank;
      rec_cnt <= next_rec_cnt;
      illegal_o <= next_illegal;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data_i;
  end

  // ==========================================================
  // bank rows and precharge timers
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      bank_open <= 2'h0;
      pre_cnt[0] <= 2'h0;
      pre_cnt[1] <= 2'h0;
    end
    else
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (pre_req[b] && bank_open[b])
        begin
          bank_open[b] <= 1'b0;
          pre_cnt[b] <= sdbis_pkg::PRE_LOAD;
        end
        else if (pre_cnt[b] != 2'h0)
          pre_cnt[b] <= pre_cnt[b] - 2'h1;
        else if (info.kind == sdbis_pkg::CMD_ROW_OPEN && info.bank == 1'(b)
                 && (state == sdbis_pkg::B_NONE || state == sdbis_pkg::B_READ))
          bank_open[b] <= 1'b1;
      end
    end
  end

  assign bank_active_o = bank_open;
  assign precharging_o = {pre_cnt[1] != 2'h0, pre_cnt[0] != 2'h0};
  assign burst_state_o = state;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  rd_to_wr_a: assert property (state == sdbis_pkg::B_READ && go_store && !info.a10
    |=> state == sdbis_pkg::B_WRITE && cnt == 3'h1)
    else $error("store did not cut read burst");
  rd_close_a: assert property (state == sdbis_pkg::B_READ && !rd_step
    && info.kind == sdbis_pkg::CMD_CLOSE && (close_mask & bank_open) != 2'h0
    |=> state == sdbis_pkg::B_NONE && precharging_o != 2'h0)
    else $error("close did not end read burst");
  wr_done_a: assert property (state == sdbis_pkg::B_WRITE && !go_store && !go_read
    && info.kind == sdbis_pkg::CMD_NOP && cnt == sdbis_pkg::BURST_LAST
    |=> state == sdbis_pkg::B_WREC)
    else $error("write burst did not reach recovery");
  wr_stop_a: assert property (state == sdbis_pkg::B_WRITE
    && info.kind == sdbis_pkg::CMD_BURST_STOP
    |=> state == sdbis_pkg::B_NONE && bank_active_o == $past(bank_active_o))
    else $error("stop did not cut write burst");
  wr_to_rd_a: assert property (state == sdbis_pkg::B_WRITE && go_read
    |=> (state == sdbis_pkg::B_READ || state == sdbis_pkg::B_READ_AC) && cnt == 3'h0)
    else $error("read did not end write burst");
  wr_restart_a: assert property (state == sdbis_pkg::B_WRITE && go_store
    |=> col == $past(info.col) && cnt == 3'h1)
    else $error("write did not restart at new column");
  wr_close_a: assert property (state == sdbis_pkg::B_WRITE
    && info.kind == sdbis_pkg::CMD_CLOSE && (close_mask & bank_open) != 2'h0
    |=> state == sdbis_pkg::B_NONE && precharging_o != 2'h0)
    else $error("close did not cut write burst");
  rdac_end_a: assert property (state == sdbis_pkg::B_READ_AC && rd_step
    && cnt == sdbis_pkg::BURST_LAST
    |=> state == sdbis_pkg::B_NONE && !bank_open[bank] && precharging_o[bank])
    else $error("auto-close read did not precharge");
  rd_done_a: assert property (state == sdbis_pkg::B_READ && rd_step
    && cnt == sdbis_pkg::BURST_LAST
    |=> state == sdbis_pkg::B_NONE && bank_open[bank])
    else $error("read burst did not finish row-active");
  rd_stop_a: assert property (state == sdbis_pkg::B_READ
    && info.kind == sdbis_pkg::CMD_BURST_STOP
    |=> state == sdbis_pkg::B_NONE && !rd_step)
    else $error("stop did not halt read burst");
  rd_restart_a: assert property (state == sdbis_pkg::B_READ && go_read
    |=> cnt == 3'h0 && col == $past(info.col) && bank == $past(info.bank))
    else $error("read did not restart at new column");
  wrac_pre_a: assert property (state == sdbis_pkg::B_WREC_AC && rec_cnt == 2'h0
    && info.kind != sdbis_pkg::CMD_HOLD
    |=> state == sdbis_pkg::B_NONE && precharging_o[bank])
    else $error("auto-close write did not precharge");

endmodule : sdbis_burst_ctrl

/* File: design/sdbis_cmd_decode.sv */
// command decoder: strobe pins to one command kind
// assumes pins are synchronous to the clock; no state inside
`timescale 1ns/1ps
module sdbis_cmd_decode (
  input wire logic cke_i,
  input wire sdbis_pkg::sdbis_pins_t pins_i,
  output sdbis_pkg::sdbis_cmd_info_t info_o
);

  always_comb
  begin
    info_o.bank = pins_i.bank;
    info_o.a10 = pins_i.a10;
    info_o.col = pins_i.col;
    // clock enable low: nothing is sampled this edge
    if (!cke_i)
      info_o.kind = sdbis_pkg::CMD_HOLD;
    else if (pins_i.cs_n)
      info_o.kind = sdbis_pkg::CMD_NOP; // deselect_cycle acts as no-op
    else
    begin
      unique case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
        3'h7: info_o.kind = sdbis_pkg::CMD_NOP;
        3'h6: info_o.kind = sdbis_pkg::CMD_BURST_STOP;
        3'h5: info_o.kind = sdbis_pkg::CMD_READ;
        3'h4: info_o.kind = sdbis_pkg::CMD_STORE;
        3'h3: info_o.kind = sdbis_pkg::CMD_ROW_OPEN;
        3'h2: info_o.kind = sdbis_pkg::CMD_CLOSE;
        3'h1: info_o.kind = sdbis_pkg::CMD_REFRESH;
        3'h0: info_o.kind = sdbis_pkg::CMD_MODE_LOAD;
      endcase
    end
  end

endmodule : sdbis_cmd_decode

/* File: design/sdbis_fifo.sv */
// read data fifo with valid/ready on both sides
// assumes one clock; depth a power of two
`timescale 1ns/1ps
module sdbis_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = count != (AW+1)'(DEPTH);
  assign out_valid_o = count != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = store[rd_ptr];

  always_ff @(posedge clock_i)
  begin
    if (push)
      store[wr_ptr] <= in_data_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule : sdbis_fifo

/* File: design/sdbis_pkg.sv */
// constants, command and state types for the sdram burst interrupt block
// assumes a 50 MHz clock and commands sampled on every rising edge
// Behaviour
// - column_store cuts a read, starts new write
// - close during read ends it, precharges banks
// - write continues on idle, then write recovery
// - burst_stop cuts write, bank stays row-active
// - column read ends write, starts new read
// - new column_store restarts write at new column
// - close during write cuts it, precharges banks
// - auto-close read completes, then self precharge
// - plain read completes, bank stays row-active
// - burst_stop halts read, bank stays row-active
// - new column read restarts read at column
// - auto-close write completes, recovers, then precharges
package sdbis_pkg;

  // ==========================================================
  // sizes and timing
  localparam int unsigned DATA_W = 16;
  localparam int unsigned COL_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned BURST_LEN = 4;
  localparam logic [2:0] BURST_LAST = 3'(BURST_LEN - 1);
  localparam logic [2:0] BURST_FIRST_NEXT = 3'h1;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_DPL_NS = 20;
  localparam int unsigned T_RP_NS = 40;
  // least times round up
  localparam int unsigned WR_REC_CYC = (T_DPL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRE_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] WR_REC_LOAD = 2'(WR_REC_CYC - 1);
  localparam logic [1:0] PRE_LOAD = 2'(PRE_CYC);

  // ==========================================================
  // pin group and decoded commands
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank;
    logic a10;
    logic [COL_W-1:0] col;
  } sdbis_pins_t;

  typedef enum logic [3:0] {
    CMD_HOLD,
    CMD_NOP,
    CMD_BURST_STOP,
    CMD_READ,
    CMD_STORE,
    CMD_ROW_OPEN,
    CMD_CLOSE,
    CMD_REFRESH,
    CMD_MODE_LOAD
  } sdbis_cmd_t;

  typedef struct packed {
    sdbis_cmd_t kind;
    logic bank;
    logic a10;
    logic [COL_W-1:0] col;
  } sdbis_cmd_info_t;

  typedef enum logic [2:0] {
    B_NONE,
    B_READ,
    B_READ_AC,
    B_WRITE,
    B_WRITE_AC,
    B_WREC,
    B_WREC_AC
  } sdbis_burst_t;

endpackage : sdbis_pkg
